// >>> hdl/adc_trig_params.svh
// Offsets, field positions, reset values and timing counts of the trigger block
`ifndef ADC_TRIG_PARAMS_SVH
`define ADC_TRIG_PARAMS_SVH

// Register indices; the byte address is four times the index
`define IDX_CONVERTER_CTRL_A 8'h7a
`define IDX_TRIGGER_SELECT 8'h7b
`define IDX_INPUT_DISABLE 8'h7e
`define IDX_IRQ_STATUS 8'h80
`define IDX_IRQ_MASK 8'h81
`define IDX_PIN_STATE 8'h82

// Field positions in converter_ctrl_a
`define CTRL_EN_BIT 7
`define CTRL_START_BIT 6
`define CTRL_AUTO_BIT 5
`define CTRL_DONE_BIT 4

// Field width of the trigger source selection
`define TRIG_SEL_W 3

// Interrupt status bits
`define IRQ_DONE_BIT 0
`define IRQ_TRIG_BIT 1
`define IRQ_W 2

// Reset values
`define RST_BYTE 8'h00
`define RST_IRQ 2'h0

// Timing counts in mclk cycles
`define SYNC_STAGES 2

`endif

// >>> hdl/adc_trig_pkg.sv
// Types shared by the trigger block
`default_nettype none
package adc_trig_pkg;

    // Selectable start sources
    typedef enum logic [2:0] {
        SRC_FREE_RUN = 3'h0,
        SRC_COMPARATOR = 3'h1,
        SRC_EXT_IRQ0 = 3'h2,
        SRC_T0_CMP_A = 3'h3,
        SRC_T0_OVF = 3'h4,
        SRC_T1_CMP_B = 3'h5,
        SRC_T1_OVF = 3'h6,
        SRC_T1_CAPTURE = 3'h7
    } trig_source_type;

    // Bus response codes
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_type;

endpackage
`default_nettype wire

// >>> hdl/pin_sync.sv
// Two-stage synchroniser for the analog channel pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // Only the second stage is read outside this module
    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
        end
    end

    assign pin_sync_out = stage2_reg;
endmodule
`default_nettype wire

// >>> hdl/trigger_select.sv
// Source selection and edge detection for automatic conversion start
`timescale 1ns/1ns
`default_nettype none
module trigger_select (
    input wire logic mclk,
    input wire logic srst,
    input wire logic auto_trigger_en,
    input wire logic converter_en,
    input wire logic [2:0] trigger_source_sel,
    input wire logic [7:1] event_flags,
    input wire logic conv_done,
    output logic trig_fire
);
    logic flag_prev_reg;
    logic flag_prev_next;
    logic fire_reg;
    logic fire_next;
    logic sel_flag;
    logic sel_edge;

    // Pick the flag of the selected source; free running watches no flag
    // source table
    always_comb begin
        if (trigger_source_sel == adc_trig_pkg::SRC_FREE_RUN) begin
            sel_flag = 1'b0;
        end else begin
            sel_flag = event_flags[trigger_source_sel];
        end
    end

    assign sel_edge = sel_flag & ~flag_prev_reg;

    // Fire only when enabled; free running restarts on each completion
    always_comb begin
        flag_prev_next = sel_flag;
        fire_next = 1'b0;
        if (auto_trigger_en && converter_en) begin
            if (trigger_source_sel == adc_trig_pkg::SRC_FREE_RUN) begin
                fire_next = conv_done;
            end else begin
                fire_next = sel_edge;
            end
        end
    end

    // Register flag history and the fire pulse
    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_prev_reg <= 1'b0;
            fire_reg <= 1'b0;
        end else begin
            flag_prev_reg <= flag_prev_next;
            fire_reg <= fire_next;
        end
    end

    assign trig_fire = fire_reg;
endmodule
`default_nettype wire

// >>> hdl/adc_auto_trigger_select.sv
// Trigger selection, input disable and conversion start control with AXI4-Lite slave
// Functional notes
// - With auto trigger on, the 3-bit source field picks free run, comparator, ext irq 0, t0 cmp A, t0 ovf, t1 cmp B, t1 ovf or t1 capture.
// - With auto trigger off, the source field has no effect and no source starts a conversion.
// - Outside free running, a conversion is auto started only on a zero-to-one change of the selected flag against its previous cycle.
// - Switching from a clear source to a set source counts as a rising trigger edge.
// - Such an edge starts a conversion only while the converter is enabled, and is dropped otherwise.
// - Switching to free running never yields a trigger, even with the done flag already set.
// - Each input disable bit set to one turns off that channel's digital input buffer.
// - A channel's pin input bit reads as zero from one cycle after its disable bit turns one.
// - Writing one to the auto trigger enable lets the selected edge start conversions.
// - The done flag is set when a conversion finishes and its result is updated.
`timescale 1ns/1ns
`default_nettype none
`include "adc_trig_params.svh"
module adc_auto_trigger_select #(
    parameter int ADDR_W = 12,
    parameter int CHANNELS = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:1] event_flags,
    input wire logic conv_done,
    input wire logic [CHANNELS-1:0] analog_pin_level,
    output logic conv_start,
    output logic [CHANNELS-1:0] channel_input_off,
    output logic [CHANNELS-1:0] pin_input_value,
    output logic irq
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 11 and 32");
    end
    if (CHANNELS != 8) begin : g_bad_ch
        $error("CHANNELS must be 8");
    end

    // Word index of a byte address, or all ones when out of range
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        if (addr[ADDR_W-1:10] != '0 || addr[1:0] != 2'h0) begin
            word_index = 8'hff;
        end else begin
            word_index = addr[9:2];
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [7:0] aw_idx_reg, aw_idx_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic converter_en_reg, converter_en_next;
    logic auto_trigger_en_reg, auto_trigger_en_next;
    logic busy_reg, busy_next;
    logic done_flag_reg, done_flag_next;
    logic [`TRIG_SEL_W-1:0] trig_sel_reg, trig_sel_next;
    logic [7:0] input_off_reg, input_off_next;
    logic [`IRQ_W-1:0] irq_status_reg, irq_status_next;
    logic [`IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic start_reg, start_next;
    logic irq_reg, irq_next;
    logic [7:0] pin_value_reg, pin_value_next;
    logic [CHANNELS-1:0] pin_synced;
    logic trig_fire;
    logic do_write;
    logic wr_lane0;
    logic sw_start;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    // Pin levels come from outside the clock domain
    pin_sync #(.WIDTH(CHANNELS)) u_pin_sync (
        .mclk(mclk),
        .srst(srst),
        .pin_async(analog_pin_level),
        .pin_sync_out(pin_synced)
    );

    // Auto trigger edge detection
    trigger_select u_trigger_select (
        .mclk(mclk),
        .srst(srst),
        .auto_trigger_en(auto_trigger_en_reg),
        .converter_en(converter_en_reg),
        .trigger_source_sel(trig_sel_reg),
        .event_flags(event_flags),
        .conv_done(conv_done),
        .trig_fire(trig_fire)
    );

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_lane0 = do_write && wstrb0_reg;

    // Address and data are caught in either order, then written together
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        aw_idx_next = aw_idx_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_next = 1'b1;
            aw_idx_next = word_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && !w_held_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata[7:0];
            wstrb0_next = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = adc_trig_pkg::RESP_OKAY;
            if (aw_idx_reg != `IDX_CONVERTER_CTRL_A && aw_idx_reg != `IDX_TRIGGER_SELECT &&
                aw_idx_reg != `IDX_INPUT_DISABLE && aw_idx_reg != `IDX_IRQ_STATUS &&
                aw_idx_reg != `IDX_IRQ_MASK && aw_idx_reg != `IDX_PIN_STATE) begin
                bresp_next = adc_trig_pkg::RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // Read decode; reads have no side effects
    always_comb begin
        logic [7:0] ridx;
        ridx = word_index(s_axi_araddr);
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = adc_trig_pkg::RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (ridx == `IDX_CONVERTER_CTRL_A) begin
                rdata_next[`CTRL_EN_BIT] = converter_en_reg;
                rdata_next[`CTRL_START_BIT] = busy_reg;
                rdata_next[`CTRL_AUTO_BIT] = auto_trigger_en_reg;
                rdata_next[`CTRL_DONE_BIT] = done_flag_reg;
            end else if (ridx == `IDX_TRIGGER_SELECT) begin
                rdata_next[`TRIG_SEL_W-1:0] = trig_sel_reg;
            end else if (ridx == `IDX_INPUT_DISABLE) begin
                rdata_next[7:0] = input_off_reg;
            end else if (ridx == `IDX_IRQ_STATUS) begin
                rdata_next[`IRQ_W-1:0] = irq_status_reg;
            end else if (ridx == `IDX_IRQ_MASK) begin
                rdata_next[`IRQ_W-1:0] = irq_mask_reg;
            end else if (ridx == `IDX_PIN_STATE) begin
                rdata_next[7:0] = pin_value_reg;
            end else begin
                rresp_next = adc_trig_pkg::RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control registers and conversion start
    // ------------------------------------------------------------
    always_comb begin
        converter_en_next = converter_en_reg;
        auto_trigger_en_next = auto_trigger_en_reg;
        trig_sel_next = trig_sel_reg;
        input_off_next = input_off_reg;
        irq_mask_next = irq_mask_reg;
        done_flag_next = done_flag_reg;
        irq_status_next = irq_status_reg;
        sw_start = 1'b0;
        if (wr_lane0 && aw_idx_reg == `IDX_CONVERTER_CTRL_A) begin
            converter_en_next = wdata_reg[`CTRL_EN_BIT];
            auto_trigger_en_next = wdata_reg[`CTRL_AUTO_BIT];
            // start bit launches only when written with the enable bit set, zero has no effect
            sw_start = wdata_reg[`CTRL_START_BIT] & wdata_reg[`CTRL_EN_BIT];
            if (wdata_reg[`CTRL_DONE_BIT]) begin
                done_flag_next = 1'b0;
            end
        end
        if (wr_lane0 && aw_idx_reg == `IDX_TRIGGER_SELECT) begin
            // only the source field is stored
            trig_sel_next = wdata_reg[`TRIG_SEL_W-1:0];
        end
        if (wr_lane0 && aw_idx_reg == `IDX_INPUT_DISABLE) begin
            input_off_next = wdata_reg;
        end
        if (wr_lane0 && aw_idx_reg == `IDX_IRQ_MASK) begin
            irq_mask_next = wdata_reg[`IRQ_W-1:0];
        end
        if (wr_lane0 && aw_idx_reg == `IDX_IRQ_STATUS) begin
            irq_status_next = irq_status_reg & ~wdata_reg[`IRQ_W-1:0];
        end
        // Hardware sets win over a clear in the same cycle
        // done flag on completion
        if (conv_done && busy_reg) begin
            done_flag_next = 1'b1;
            irq_status_next[`IRQ_DONE_BIT] = 1'b1;
        end
        if (trig_fire) begin
            irq_status_next[`IRQ_TRIG_BIT] = 1'b1;
        end
    end

    // Start pulse and busy tracking; disabling aborts a running conversion
    always_comb begin
        start_next = 1'b0;
        busy_next = busy_reg;
        if (conv_done) begin
            busy_next = 1'b0;
        end
        if ((sw_start || trig_fire) && converter_en_next && !busy_next) begin
            start_next = 1'b1;
            busy_next = 1'b1;
        end
        if (!converter_en_next) begin
            busy_next = 1'b0;
        end
    end

    // Pin view and interrupt level
    always_comb begin
        pin_value_next = pin_synced & ~input_off_reg;
        irq_next = |(irq_status_reg & irq_mask_reg);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= `RST_BYTE;
            wdata_reg <= `RST_BYTE;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= adc_trig_pkg::RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= adc_trig_pkg::RESP_OKAY;
            converter_en_reg <= 1'b0;
            auto_trigger_en_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_flag_reg <= 1'b0;
            trig_sel_reg <= '0;
            input_off_reg <= `RST_BYTE;
            irq_status_reg <= `RST_IRQ;
            irq_mask_reg <= `RST_IRQ;
            start_reg <= 1'b0;
            irq_reg <= 1'b0;
            pin_value_reg <= `RST_BYTE;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            aw_idx_reg <= aw_idx_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            converter_en_reg <= converter_en_next;
            auto_trigger_en_reg <= auto_trigger_en_next;
            busy_reg <= busy_next;
            done_flag_reg <= done_flag_next;
            trig_sel_reg <= trig_sel_next;
            input_off_reg <= input_off_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            start_reg <= start_next;
            irq_reg <= irq_next;
            pin_value_reg <= pin_value_next;
        end
    end

    // Outputs straight from flip-flops; awready and wready are the inverted held flags
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign conv_start = start_reg;
    assign channel_input_off = input_off_reg;
    assign pin_input_value = pin_value_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

// >>> tb/trig_checker_assertions.sv
// Port-level assertions for the trigger select block
`timescale 1ns/1ns
`default_nettype none
`include "adc_trig_params.svh"
module trig_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_start,
    input wire logic [7:0] channel_input_off,
    input wire logic [7:0] pin_input_value,
    input wire logic irq
);
    localparam logic [ADDR_W-1:0] SEL_ADDR = ADDR_W'(4 * `IDX_TRIGGER_SELECT);
    localparam logic [ADDR_W-1:0] DIS_ADDR = ADDR_W'(4 * `IDX_INPUT_DISABLE);
    logic both_take;

    // Address and data taken on the same edge
    assign both_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    reset_state_a: assert property ($fell(srst) |-> s_axi_awready && s_axi_wready
        && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !conv_start && !irq)
        else $error("outputs not at idle values after reset");
    write_answer_a: assert property (both_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read response late");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    sel_unused_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == SEL_ADDR
        |=> s_axi_rdata[31:3] == 29'h0) else $error("unused select bits read nonzero");
    buffer_off_a: assert property (
        both_take && s_axi_awaddr == DIS_ADDR && s_axi_wstrb[0]
        |-> ##2 channel_input_off == $past(s_axi_wdata[7:0], 2))
        else $error("input disable not applied");
    pin_mask_a: assert property (
        $stable(channel_input_off) |-> (pin_input_value & channel_input_off) == 8'h00)
        else $error("disabled pin reads one");
endmodule
bind adc_auto_trigger_select trig_checker #(.ADDR_W(ADDR_W)) chk_u (.mclk, .srst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conv_start, .channel_input_off, .pin_input_value, .irq);
`default_nettype wire

// >>> tb/event_src_model.sv
// Event sources and conversion engine that sit beside the trigger block
`timescale 1ns/1ns
`default_nettype none
module event_src_model #(
    parameter int CONV_CYCLES = 13
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic conv_start,
    input wire logic [7:1] flag_cmd,
    output logic [7:1] event_flags,
    output logic conv_done
);
    int left;

    // done pulse at end of conversion
    always_ff @(posedge mclk) begin
        if (srst) begin
            event_flags <= 7'h00;
            left <= 0;
            conv_done <= 1'h0;
        end else begin
            event_flags <= flag_cmd;
            conv_done <= (left == 1);
            if (conv_start) begin
                left <= CONV_CYCLES;
            end else if (left != 0) begin
                left <= left - 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the auto trigger select block
`timescale 1ns/1ns
`default_nettype none
`include "adc_trig_params.svh"
module tb_top;
    typedef struct {
        logic [2:0] sel;
        logic [7:1] flags;
        logic [7:0] ctrl;
        int starts;
    } row_type;
    logic mclk = 1'h0, srst = 1'h1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done, irq;
    logic [1:0] bresp, rresp, resp;
    logic [7:1] flag_cmd = 7'h00, event_flags;
    logic [7:0] pins = 8'h00, chan_off, pin_val;
    logic [7:0] idxs [5] = '{`IDX_CONVERTER_CTRL_A, `IDX_TRIGGER_SELECT,
        `IDX_INPUT_DISABLE, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
    row_type rows [10] = '{'{3'h1, 7'h01, 8'ha0, 1}, '{3'h2, 7'h02, 8'ha0, 1},
        '{3'h3, 7'h04, 8'ha0, 1}, '{3'h4, 7'h08, 8'ha0, 1}, '{3'h5, 7'h10, 8'ha0, 1},
        '{3'h6, 7'h20, 8'ha0, 1}, '{3'h7, 7'h40, 8'ha0, 1}, '{3'h3, 7'h08, 8'ha0, 0},
        '{3'h5, 7'h7f, 8'h80, 0}, '{3'h6, 7'h20, 8'h20, 0}};
    int fails = 0, samples_checked = 0, starts = 0, s0;

    event_src_model src_u (.mclk, .srst, .conv_start, .flag_cmd, .event_flags, .conv_done);
    adc_auto_trigger_select dut_u (.mclk, .srst, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .event_flags, .conv_done, .analog_pin_level(pins),
        .conv_start, .channel_input_off(chan_off), .pin_input_value(pin_val), .irq);

    // Clock and start pulse counter
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (conv_start === 1'h1) starts <= starts + 1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Bus write: both channels offered together, bready raised only once the answer is seen
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic a, w, b, v;
        int n;
        n = 0;
        b = 1'h0;
        @(posedge mclk);
        awaddr <= 12'({idx, 2'h0});
        wdata <= {24'h0, val};
        wstrb <= 4'h1;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!b && n < 100) begin
            @(negedge mclk);
            a = awvalid && awready;
            w = wvalid && wready;
            v = (bvalid === 1'h1);
            b = v && bready;
            resp = bresp;
            n++;
            @(posedge mclk);
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
            bready <= v && !b;
        end
        if (!b) fails++;
    endtask
    // Bus read: rready raised only once the answer is seen
    task automatic rd_reg(input logic [7:0] idx);
        logic a, r, v;
        int n;
        n = 0;
        r = 1'h0;
        @(posedge mclk);
        araddr <= 12'({idx, 2'h0});
        arvalid <= 1'h1;
        while (!r && n < 100) begin
            @(negedge mclk);
            a = arvalid && arready;
            v = (rvalid === 1'h1);
            r = v && rready;
            rd = rdata;
            resp = rresp;
            n++;
            @(posedge mclk);
            if (a) arvalid <= 1'h0;
            rready <= v && !r;
        end
        if (!r) fails++;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic expect_starts(input string name, input int win, input int exp);
        settle(win);
        check(name, starts - s0, exp);
        @(posedge mclk);
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'h0;
        // Reset values of all registers but pin state, unmapped place
        foreach (idxs[i]) begin
            rd_reg(idxs[i]);
            check("reset value", rd, 32'h0);
        end
        rd_reg(8'h7c);
        check("unmapped read", resp, 2'h2);
        wr(8'h7c, 8'hff);
        check("unmapped write", resp, 2'h2);
        // Source table
        foreach (rows[i]) begin
            wr(`IDX_TRIGGER_SELECT, {5'h0, rows[i].sel});
            wr(`IDX_CONVERTER_CTRL_A, rows[i].ctrl);
            s0 = starts;
            flag_cmd <= rows[i].flags;
            expect_starts("row starts", 30, rows[i].starts);
            flag_cmd <= 7'h00;
            wr(`IDX_CONVERTER_CTRL_A, 8'h00);
        end
        // Switching source from clear to set flag
        flag_cmd <= 7'h02;
        wr(`IDX_TRIGGER_SELECT, 8'h01);
        wr(`IDX_CONVERTER_CTRL_A, 8'h20);
        s0 = starts;
        wr(`IDX_TRIGGER_SELECT, 8'h02);
        expect_starts("switch converter off", 30, 0);
        wr(`IDX_TRIGGER_SELECT, 8'h01);
        wr(`IDX_CONVERTER_CTRL_A, 8'hb0);
        s0 = starts;
        wr(`IDX_TRIGGER_SELECT, 8'h02);
        expect_starts("switch converter on", 30, 1);
        rd_reg(`IDX_CONVERTER_CTRL_A);
        check("done flag", rd & 32'h10, 32'h10);
        s0 = starts;
        wr(`IDX_TRIGGER_SELECT, 8'h00);
        expect_starts("switch to free run", 30, 0);
        // Free running chain and its stop
        flag_cmd <= 7'h00;
        s0 = starts;
        wr(`IDX_CONVERTER_CTRL_A, 8'he0);
        settle(80);
        check("free run restarts", (starts - s0) >= 3, 1);
        wr(`IDX_CONVERTER_CTRL_A, 8'h00);
        repeat (20) @(posedge mclk);
        s0 = starts;
        expect_starts("free run stopped", 40, 0);
        wr(`IDX_TRIGGER_SELECT, 8'h7f);
        rd_reg(`IDX_TRIGGER_SELECT);
        check("select unused bits", rd, 32'h7);
        // Interrupt masked, unmasked, cleared
        wr(`IDX_IRQ_MASK, 8'h00);
        wr(`IDX_IRQ_STATUS, 8'h03);
        wr(`IDX_CONVERTER_CTRL_A, 8'hc0);
        settle(30);
        check("irq masked", irq, 1'h0);
        rd_reg(`IDX_IRQ_STATUS);
        check("irq status", rd, 32'h1);
        wr(`IDX_IRQ_MASK, 8'h01);
        settle(3);
        check("irq raised", irq, 1'h1);
        wr(`IDX_IRQ_STATUS, 8'h01);
        settle(3);
        check("irq cleared", irq, 1'h0);
        // Input buffers off and pin values
        @(posedge mclk);
        pins <= 8'hff;
        wr(`IDX_INPUT_DISABLE, 8'ha5);
        settle(5);
        check("buffers off", chan_off, 8'ha5);
        check("pin values", pin_val, 8'h5a);
        // Reset in mid run
        @(posedge mclk);
        srst <= 1'h1;
        settle(2);
        check("reset outputs", chan_off, 8'h00);
        @(posedge mclk);
        srst <= 1'h0;
        rd_reg(`IDX_INPUT_DISABLE);
        check("disable after reset", rd, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
